// ===== rtl/hss_pkg.sv
// Shared constants, codes and helpers for the hot-standby switchover pair
package hss_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam logic [6:0]  ADDR_WRAP     = 7'h7d;
  localparam logic [6:0]  HSL_MAX       = 7'h7d;
  localparam logic [6:0]  ADDR_BCAST    = 7'h7f;
  localparam logic [6:0]  RST_ADDR      = 7'h00;
  localparam logic [15:0] FI_OK         = 16'h0000;
  localparam logic [15:0] FI_PARAM      = 16'h0006;
  localparam logic [15:0] AFI_SBY_ADDR  = 16'h0013;
  localparam logic [15:0] AFI_MODE      = 16'h0005;
  localparam logic [15:0] FI_REFUSED    = 16'h00fd;
  localparam int unsigned SF_CLASS2_ONLY = 5;
  // Mailbox request codes
  localparam logic [3:0] MBX_INIT        = 4'h1;
  localparam logic [3:0] MBX_SET_SLV     = 4'h2;
  localparam logic [3:0] MBX_GET_MDIAG   = 4'h3;
  localparam logic [3:0] MBX_GET_SDIAG   = 4'h4;
  localparam logic [3:0] MBX_PROF_PARAM  = 4'h5;
  // Telegram kinds towards the bus engine
  localparam logic [1:0] TEL_GLOBAL_CTRL = 2'h0;
  localparam logic [1:0] TEL_SLAVE_DIAG  = 2'h1;
  localparam logic [1:0] TEL_DATA_EXCH   = 2'h2;
  // Timing
  localparam int unsigned MAC_RESET_NS  = 64;
  localparam int unsigned MAC_RESET_CYC = (MAC_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLINK_HALF_MS  = 250;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  // Host register map
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CFG      = 8'h04;
  localparam logic [7:0] REG_MBX      = 8'h08;
  localparam logic [7:0] REG_MBX_RES  = 8'h0c;
  localparam logic [7:0] REG_STATUS   = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;
  localparam int unsigned IRQ_LINK_LOST = 0;
  localparam int unsigned IRQ_FRESH     = 1;
  localparam int unsigned IRQ_MBX_DONE  = 2;
  localparam int unsigned IRQ_W         = 3;

  function automatic logic [6:0] standby_addr(input logic [6:0] stn);
    standby_addr = (stn == 7'h00) ? ADDR_WRAP : 7'(stn - 7'h01);
  endfunction : standby_addr
endpackage : hss_pkg

// ===== rtl/hss_if.sv
// Link between the standby master and its host application
`timescale 1ns/1ps
interface hss_if;
  logic        takeover;
  logic        fresh_ack;
  logic        mbx_req;
  logic [3:0]  mbx_code;
  logic [7:0]  mbx_special;
  logic [6:0]  this_station_address;
  logic [6:0]  highest_station_limit;
  logic        link_ok;
  logic        fresh_output_flag;
  logic        role_active;
  logic        mbx_ack;
  logic [15:0] mbx_fault;
  logic [15:0] mbx_add_fault;

  modport dev (input takeover, fresh_ack, mbx_req, mbx_code, mbx_special, this_station_address,
               highest_station_limit,
               output link_ok, fresh_output_flag, role_active, mbx_ack, mbx_fault, mbx_add_fault);
  modport host (output takeover, fresh_ack, mbx_req, mbx_code, mbx_special, this_station_address,
                highest_station_limit,
                input link_ok, fresh_output_flag, role_active, mbx_ack, mbx_fault, mbx_add_fault);
endinterface : hss_if

// ===== rtl/hss_blink.sv
// Slow flasher driven by a divider enable pulse
`timescale 1ns/1ps
module hss_blink #(
  parameter int unsigned P_HALF_CYC = 16
) (
  input  logic i_clk_sys,
  input  logic i_sys_rst,
  input  logic i_en,
  output logic o_blink
);
  logic [31:0] cnt_r;
  logic        tick_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_en) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b0;
    end else if (cnt_r >= 32'(P_HALF_CYC - 1)) begin
      cnt_r  <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_en) begin
      o_blink <= 1'b0;
    end else if (tick_r) begin
      o_blink <= ~o_blink;
    end
  end
endmodule : hss_blink

// ===== rtl/hss_standby_master.sv
// Redundant fieldbus master end: roles, switchover sequence, mailbox checks, indicators
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RULE_01: Clear link bit when counterpart fails
// RULE_02: Host alone decides to start switchover
// RULE_03: Switchover resets MAC, restarts with station address
// RULE_04: First telegram after reinit is GlobalCtrl
// RULE_05: Then SlaveDiag to every slave
// RULE_06: Then DataExchange to all slaves
// RULE_07: Set fresh flag when new data present
// RULE_08: Host reads output area only after flag
// RULE_09: Configurer doubles target token rotation time
// RULE_10: Configurer extends slave watchdog for switchover
// RULE_11: Address above station limit stays out of ring
// RULE_12: Standby uses station address minus one
// RULE_13: Station address zero wraps to 125
// RULE_14: Active master switches to station address itself
// RULE_15: Wrapped 125 with limit below: reject init
// RULE_16: Standby flashes master indicator red
// RULE_17: Comm indicator same in every role
// RULE_18: Standby refuses four mailbox requests with 0x00fd
// RULE_19: Class-2-only mode never allowed when redundant
module hss_standby_master
  import hss_pkg::*;
#(
  parameter int unsigned P_BLINK_CYC = BLINK_HALF_CYC
) (
  input  logic       i_clk_sys,
  input  logic       i_sys_rst,
  hss_if.dev         hif,
  input  logic       i_peer_alive,
  input  logic       i_data_fresh,
  input  logic [6:0] i_num_slaves,
  input  logic       i_tel_ready,
  output logic       o_tel_valid,
  output logic [1:0] o_tel_kind,
  output logic [6:0] o_tel_dest,
  output logic       o_mac_reset,
  output logic [6:0] o_bus_addr,
  output logic       o_in_ring,
  output logic       o_led_red,
  output logic       o_led_green,
  output logic       o_led_com
);
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_MAC_RESET,
    ST_GCTRL,
    ST_DIAG,
    ST_DX
  } hss_state_t;

  hss_state_t  state_r;
  logic [7:0]  rst_cnt_r;
  logic [6:0]  idx_r;
  logic        active_r;
  logic        init_done_r;
  logic        round_done_r;
  logic [6:0]  stn_r;
  logic [6:0]  hsl_r;
  logic        link_r;
  logic        fresh_r;
  logic        ack_r;
  logic [15:0] fault_r;
  logic [15:0] add_fault_r;
  logic [15:0] fault_nxt;
  logic [15:0] add_fault_nxt;
  logic        init_ok_nxt;
  logic        blink;
  logic        tel_take;
  logic        last_slave;

  assign tel_take   = o_tel_valid && i_tel_ready;
  assign last_slave = (idx_r >= 7'(i_num_slaves - 7'h01));

  // Counterpart supervision; the link bit is the host's only failure view
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      link_r <= 1'b0;
    end else begin
      link_r <= i_peer_alive; // RULE_01
    end
  end

  // Switchover sequence and telegram issue
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_r      <= ST_STANDBY;
      rst_cnt_r    <= 8'h0;
      idx_r        <= 7'h0;
      active_r     <= 1'b0;
      round_done_r <= 1'b0;
      o_tel_valid  <= 1'b0;
      o_tel_kind   <= TEL_GLOBAL_CTRL;
      o_tel_dest   <= RST_ADDR;
      o_mac_reset  <= 1'b0;
    end else begin
      case (state_r)
        ST_STANDBY: begin
          // No takeover without the host's command
          if (hif.takeover && init_done_r) begin // RULE_02
            state_r     <= ST_MAC_RESET;
            active_r    <= 1'b1; // RULE_14
            o_mac_reset <= 1'b1; // RULE_03
            rst_cnt_r   <= 8'(MAC_RESET_CYC - 1);
          end
        end
        ST_MAC_RESET: begin
          if (rst_cnt_r == 8'h0) begin
            o_mac_reset <= 1'b0;
            state_r     <= ST_GCTRL;
            o_tel_valid <= 1'b1;
            o_tel_kind  <= TEL_GLOBAL_CTRL; // RULE_04
            o_tel_dest  <= ADDR_BCAST;
          end else begin
            rst_cnt_r <= rst_cnt_r - 8'h1;
          end
        end
        ST_GCTRL: begin
          if (tel_take) begin
            idx_r      <= 7'h0;
            o_tel_dest <= 7'h0;
            if (i_num_slaves == 7'h0) begin
              o_tel_valid <= 1'b0;
              state_r     <= ST_DX;
            end else begin
              o_tel_kind <= TEL_SLAVE_DIAG; // RULE_05
              state_r    <= ST_DIAG;
            end
          end
        end
        ST_DIAG: begin
          if (tel_take) begin
            if (last_slave) begin
              idx_r      <= 7'h0;
              o_tel_dest <= 7'h0;
              o_tel_kind <= TEL_DATA_EXCH; // RULE_06
              state_r    <= ST_DX;
            end else begin
              idx_r      <= idx_r + 7'h1;
              o_tel_dest <= idx_r + 7'h1; // RULE_05
            end
          end
        end
        ST_DX: begin
          // Cyclic exchange continues as long as slaves are configured
          o_tel_valid <= (i_num_slaves != 7'h0);
          o_tel_kind  <= TEL_DATA_EXCH; // RULE_06
          if (tel_take) begin
            if (last_slave) begin
              idx_r        <= 7'h0;
              o_tel_dest   <= 7'h0;
              round_done_r <= 1'b1;
            end else begin
              idx_r      <= idx_r + 7'h1;
              o_tel_dest <= idx_r + 7'h1;
            end
          end
        end
        default: begin
          state_r     <= ST_STANDBY;
          o_tel_valid <= 1'b0;
          o_mac_reset <= 1'b0;
        end
      endcase
    end
  end

  // Fresh output flag; a new set beats the host's acknowledge
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      fresh_r <= 1'b0;
    end else if (active_r && round_done_r && i_data_fresh) begin
      fresh_r <= 1'b1; // RULE_07
    end else if (hif.fresh_ack) begin
      fresh_r <= 1'b0;
    end
  end

  // Mailbox verdict
  always_comb begin
    fault_nxt     = FI_OK;
    add_fault_nxt = FI_OK;
    init_ok_nxt   = 1'b0;
    case (hif.mbx_code)
      MBX_INIT: begin
        if (hif.mbx_special[SF_CLASS2_ONLY]) begin // RULE_19
          fault_nxt     = FI_PARAM;
          add_fault_nxt = AFI_MODE;
        end else if (standby_addr(hif.this_station_address) == ADDR_WRAP && // RULE_13
                     hif.highest_station_limit < HSL_MAX) begin // RULE_15
          fault_nxt     = FI_PARAM;
          add_fault_nxt = AFI_SBY_ADDR;
        end else begin
          init_ok_nxt = 1'b1;
        end
      end
      MBX_SET_SLV,
      MBX_GET_MDIAG,
      MBX_GET_SDIAG,
      MBX_PROF_PARAM: begin
        if (!active_r) begin
          fault_nxt = FI_REFUSED; // RULE_18
        end
      end
      default: begin
        fault_nxt = FI_OK;
      end
    endcase
  end

  // Answer one cycle after the request; configuration held from a good init
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ack_r       <= 1'b0;
      fault_r     <= FI_OK;
      add_fault_r <= FI_OK;
      init_done_r <= 1'b0;
      stn_r       <= RST_ADDR;
      hsl_r       <= RST_ADDR;
    end else begin
      ack_r <= hif.mbx_req;
      if (hif.mbx_req) begin
        fault_r     <= fault_nxt;
        add_fault_r <= add_fault_nxt;
        // Station address is frozen once active, so the role address stays stable
        if (init_ok_nxt && !active_r) begin
          init_done_r <= 1'b1;
          stn_r       <= hif.this_station_address;
          hsl_r       <= hif.highest_station_limit;
        end
      end
    end
  end

  // Bus address and ring admission
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_bus_addr <= RST_ADDR;
      o_in_ring  <= 1'b0;
    end else begin
      o_bus_addr <= active_r ? stn_r : standby_addr(stn_r); // RULE_12
      o_in_ring  <= init_done_r && !o_mac_reset && (o_bus_addr <= hsl_r); // RULE_11
    end
  end

  hss_blink #(
    .P_HALF_CYC (P_BLINK_CYC)
  ) u_blink (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_en      (init_done_r && !active_r),
    .o_blink   (blink)
  );

  // Indicators
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_led_red   <= 1'b0;
      o_led_green <= 1'b0;
      o_led_com   <= 1'b0;
    end else begin
      o_led_red   <= blink; // RULE_16
      o_led_green <= active_r;
      o_led_com   <= o_in_ring; // RULE_17
    end
  end

  assign hif.link_ok           = link_r;
  assign hif.fresh_output_flag = fresh_r;
  assign hif.role_active       = active_r;
  assign hif.mbx_ack           = ack_r;
  assign hif.mbx_fault         = fault_r;
  assign hif.mbx_add_fault     = add_fault_r;
endmodule : hss_standby_master

// ===== rtl/hss_host_app.sv
// Host application end: software registers, switchover command, mailbox, interrupt
`timescale 1ns/1ps
module hss_host_app
  import hss_pkg::*;
(
  input  logic        i_clk_sys,
  input  logic        i_sys_rst,
  hss_if.host         hif,
  input  logic [7:0]  i_addr,
  input  logic [31:0] i_wdata,
  input  logic        i_we,
  input  logic        i_re,
  output logic [31:0] o_rdata,
  output logic        o_irq
);
  logic               takeover_r;
  logic               ack_r;
  logic               mbx_req_r;
  logic [3:0]         code_r;
  logic [7:0]         special_r;
  logic [6:0]         stn_r;
  logic [6:0]         hsl_r;
  logic               busy_r;
  logic [15:0]        fault_r;
  logic [15:0]        add_fault_r;
  logic               link_q_r;
  logic               fresh_q_r;
  logic [IRQ_W-1:0]   irq_stat_r;
  logic [IRQ_W-1:0]   irq_mask_r;
  logic [IRQ_W-1:0]   irq_evt;

  // Control and configuration writes
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      takeover_r <= 1'b0;
      ack_r      <= 1'b0;
      stn_r      <= RST_ADDR;
      hsl_r      <= RST_ADDR;
    end else begin
      // Takeover only on the supervisor's explicit write
      takeover_r <= i_we && i_addr == REG_CTRL && i_wdata[0]; // RULE_02
      // Output area may be consumed only after the flag was seen
      ack_r      <= i_we && i_addr == REG_CTRL && i_wdata[1] && hif.fresh_output_flag; // RULE_08
      if (i_we && i_addr == REG_CFG) begin
        stn_r <= i_wdata[6:0];
        hsl_r <= i_wdata[14:8];
      end
    end
  end

  // Mailbox launch and result capture; writes while busy are dropped
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      mbx_req_r   <= 1'b0;
      code_r      <= 4'h0;
      special_r   <= 8'h0;
      busy_r      <= 1'b0;
      fault_r     <= FI_OK;
      add_fault_r <= FI_OK;
    end else begin
      mbx_req_r <= 1'b0;
      if (i_we && i_addr == REG_MBX && !busy_r) begin
        mbx_req_r <= 1'b1;
        code_r    <= i_wdata[3:0];
        special_r <= i_wdata[15:8];
        busy_r    <= 1'b1;
      end else if (hif.mbx_ack) begin
        busy_r      <= 1'b0;
        fault_r     <= hif.mbx_fault;
        add_fault_r <= hif.mbx_add_fault;
      end
    end
  end

  assign irq_evt[IRQ_LINK_LOST] = link_q_r && !hif.link_ok;
  assign irq_evt[IRQ_FRESH]     = !fresh_q_r && hif.fresh_output_flag;
  assign irq_evt[IRQ_MBX_DONE]  = hif.mbx_ack;

  // Sticky events, write one to clear; a new event wins
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      link_q_r   <= 1'b0;
      fresh_q_r  <= 1'b0;
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      o_irq      <= 1'b0;
    end else begin
      link_q_r  <= hif.link_ok;
      fresh_q_r <= hif.fresh_output_flag;
      if (i_we && i_addr == REG_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~i_wdata[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      if (i_we && i_addr == REG_IRQ_MASK) begin
        irq_mask_r <= i_wdata[IRQ_W-1:0];
      end
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || !i_re) begin
      o_rdata <= 32'h0;
    end else begin
      case (i_addr)
        REG_CFG:      o_rdata <= {17'h0, hsl_r, 1'b0, stn_r};
        REG_MBX:      o_rdata <= {16'h0, special_r, 4'h0, code_r};
        REG_MBX_RES:  o_rdata <= {add_fault_r, fault_r};
        REG_STATUS:   o_rdata <= {28'h0, busy_r, hif.role_active, hif.fresh_output_flag, hif.link_ok};
        REG_IRQ_STAT: o_rdata <= {29'h0, irq_stat_r};
        REG_IRQ_MASK: o_rdata <= {29'h0, irq_mask_r};
        default:      o_rdata <= 32'h0;
      endcase
    end
  end

  assign hif.takeover              = takeover_r;
  assign hif.fresh_ack             = ack_r;
  assign hif.mbx_req               = mbx_req_r;
  assign hif.mbx_code              = code_r;
  assign hif.mbx_special           = special_r;
  assign hif.this_station_address  = stn_r;
  assign hif.highest_station_limit = hsl_r;
endmodule : hss_host_app

// ===== verification/hss_link_sva.sv
// Checker on the host-device link of the standby master pair
`timescale 1ns/1ps
module hss_link_sva
  import hss_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_sys_rst,
  input wire logic        i_peer_alive,
  input wire logic        takeover,
  input wire logic        mbx_req,
  input wire logic [3:0]  mbx_code,
  input wire logic [7:0]  mbx_special,
  input wire logic [6:0]  this_station_address,
  input wire logic [6:0]  highest_station_limit,
  input wire logic        link_ok,
  input wire logic        fresh_output_flag,
  input wire logic        role_active,
  input wire logic        mbx_ack,
  input wire logic [15:0] mbx_fault,
  input wire logic [15:0] mbx_add_fault
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  ack_follows_req_a: assert property (mbx_req |=> mbx_ack)
    else $error("mailbox ack missing one cycle after request");
  ack_single_a: assert property (mbx_ack |=> !mbx_ack)
    else $error("mailbox ack longer than one cycle");
  fault_hold_a: assert property (!mbx_ack |-> $stable(mbx_fault) && $stable(mbx_add_fault))
    else $error("mailbox fault changed without ack");
  refuse_standby_a: assert property (
    mbx_req && mbx_code inside {[4'h2:4'h5]} && !role_active
    |=> mbx_fault == FI_REFUSED && mbx_add_fault == 16'h0000)
    else $error("standby did not refuse mailbox request");
  class2_reject_a: assert property (
    mbx_req && mbx_code == MBX_INIT && mbx_special[SF_CLASS2_ONLY]
    |=> mbx_fault == FI_PARAM && mbx_add_fault == AFI_MODE)
    else $error("class two only init not rejected");
  wrap_reject_a: assert property (
    mbx_req && mbx_code == MBX_INIT && !mbx_special[SF_CLASS2_ONLY] && !role_active
    && this_station_address == 7'h00 && highest_station_limit < HSL_MAX
    |=> mbx_fault == FI_PARAM && mbx_add_fault == AFI_SBY_ADDR)
    else $error("wrapped standby address init not rejected");
  link_follow_a: assert property (1'b1 |=> link_ok == $past(i_peer_alive))
    else $error("link bit does not follow peer state");
  fresh_active_a: assert property (fresh_output_flag |-> role_active)
    else $error("fresh flag set while standby");
  takeover_cause_a: assert property ($rose(role_active) |-> $past(takeover))
    else $error("role became active without host takeover");

  cover property (mbx_req && mbx_code == MBX_INIT ##1 mbx_fault == FI_PARAM);
  cover property ($rose(role_active));
  cover property ($rose(fresh_output_flag));
endmodule : hss_link_sva

// ===== verification/hot_standby_switchover_test.sv
// Self-checking bench joining host end and device end over the link
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module hot_standby_switchover_test;
  import hss_pkg::*;
  logic        i_clk_sys    = 1'b0;
  logic        i_sys_rst    = 1'b1;
  logic        i_peer_alive = 1'b1;
  logic        i_data_fresh = 1'b1;
  logic [6:0]  i_num_slaves = 7'h03;
  logic        i_tel_ready  = 1'b0;
  logic [7:0]  i_addr       = 8'h00;
  logic [31:0] i_wdata      = 32'h0;
  logic        i_we         = 1'b0;
  logic        i_re         = 1'b0;
  logic [31:0] o_rdata;
  logic        o_irq, o_tel_valid, o_mac_reset, o_in_ring, o_led_red, o_led_green, o_led_com;
  logic [1:0]  o_tel_kind;
  logic [6:0]  o_tel_dest, o_bus_addr, stn_addr;
  int          fail_count = 0;
  int          n_checks   = 0;
  int          exp_tel[$];
  int          exp_t, cnt;

  always #2 i_clk_sys = ~i_clk_sys;

  hss_if hif_link ();
  hss_host_app u_hss_host_app (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .hif(hif_link),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .o_irq(o_irq));
  hss_standby_master #(.P_BLINK_CYC(4)) u_hss_standby_master (.i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst), .hif(hif_link), .i_peer_alive(i_peer_alive), .i_data_fresh(i_data_fresh),
    .i_num_slaves(i_num_slaves), .i_tel_ready(i_tel_ready), .o_tel_valid(o_tel_valid),
    .o_tel_kind(o_tel_kind), .o_tel_dest(o_tel_dest), .o_mac_reset(o_mac_reset), .o_bus_addr(o_bus_addr),
    .o_in_ring(o_in_ring), .o_led_red(o_led_red), .o_led_green(o_led_green), .o_led_com(o_led_com));
  hss_link_sva u_sva (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_peer_alive(i_peer_alive),
    .takeover(hif_link.takeover), .mbx_req(hif_link.mbx_req), .mbx_code(hif_link.mbx_code),
    .mbx_special(hif_link.mbx_special), .this_station_address(hif_link.this_station_address),
    .highest_station_limit(hif_link.highest_station_limit), .link_ok(hif_link.link_ok),
    .fresh_output_flag(hif_link.fresh_output_flag), .role_active(hif_link.role_active),
    .mbx_ack(hif_link.mbx_ack), .mbx_fault(hif_link.mbx_fault), .mbx_add_fault(hif_link.mbx_add_fault));

  // Model of the telegram order; bus engine stalls at random
  always @(posedge i_clk_sys) begin
    if (!i_sys_rst && o_tel_valid && i_tel_ready && exp_tel.size() > 0) begin
      exp_t = exp_tel.pop_front();
      `CHK({o_tel_kind, o_tel_dest}, 9'(exp_t))
      `CHK(o_mac_reset, 1'b0)
    end
    // Engine grants only some slots; rotation time leaves room for the peer master
    i_tel_ready <= 1'($urandom % 2);
  end

  task automatic wrap_up;
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_we    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk_sys);
    i_re   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_re <= 1'b0;
    @(negedge i_clk_sys);
    `CHK(o_rdata, e)
  endtask : rd

  task automatic settle;
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask : settle

  // Busy clears two cycles after the launch write
  task automatic mbx(input logic [3:0] c, input logic [7:0] s, input logic [31:0] e);
    wr(REG_MBX, {16'h0, s, 4'h0, c});
    repeat (3) @(posedge i_clk_sys);
    rd(REG_MBX_RES, e);
  endtask : mbx

  task automatic cfg(input logic [6:0] t, input logic [6:0] lim);
    wr(REG_CFG, {17'h0, lim, 1'b0, t});
  endtask : cfg

  initial begin
    void'($urandom(32'h7430));
    repeat (16) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    rd(REG_STATUS, 32'h1);
    rd(8'h1c, 32'h0);
    cfg(7'h00, 7'h7c);
    mbx(MBX_INIT, 8'h00, {AFI_SBY_ADDR, FI_PARAM});
    cfg(7'h00, HSL_MAX);
    mbx(MBX_INIT, 8'h20, {AFI_MODE, FI_PARAM});
    mbx(MBX_INIT, 8'h00, 32'h0);
    settle();
    `CHK(o_bus_addr, ADDR_WRAP)
    `CHK(o_in_ring, 1'b1)
    stn_addr = 7'(2 + $urandom % 123);
    // Limit one below the standby address keeps it out of the ring
    cfg(stn_addr, 7'(stn_addr - 7'h02));
    mbx(MBX_INIT, 8'h00, 32'h0);
    settle();
    `CHK(o_bus_addr, 7'(stn_addr - 7'h01))
    `CHK(o_in_ring, 1'b0)
    `CHK(o_led_com, 1'b0)
    cfg(stn_addr, HSL_MAX);
    mbx(MBX_INIT, 8'h00, 32'h0);
    settle();
    `CHK(o_led_com, 1'b1)
    for (int c = 2; c <= 5; c++)
      mbx(4'(c), 8'h00, {16'h0, FI_REFUSED});
    cnt = 0;
    repeat (24) begin
      @(negedge i_clk_sys);
      if (o_led_red) cnt++;
    end
    `CHK(cnt > 4 && cnt < 20, 1'b1)
    @(posedge i_clk_sys);
    i_peer_alive <= 1'b0;
    settle();
    `CHK(hif_link.link_ok, 1'b0)
    `CHK(o_irq, 1'b0)
    rd(REG_IRQ_STAT, 32'h5);
    wr(REG_IRQ_MASK, 32'h1);
    settle();
    `CHK(o_irq, 1'b1)
    wr(REG_IRQ_STAT, 32'h5);
    settle();
    `CHK(o_irq, 1'b0)
    exp_tel.push_back({TEL_GLOBAL_CTRL, ADDR_BCAST});
    for (int k = 0; k < 9; k++)
      exp_tel.push_back({(k < 3) ? TEL_SLAVE_DIAG : TEL_DATA_EXCH, 7'(k % 3)});
    wr(REG_CTRL, 32'h1);
    cnt = 0;
    repeat (40) begin
      @(negedge i_clk_sys);
      if (o_mac_reset) cnt++;
    end
    `CHK(cnt, int'(MAC_RESET_CYC))
    `CHK(o_bus_addr, stn_addr)
    `CHK({o_led_red, o_led_green}, 2'b01)
    `CHK(o_led_com, 1'b1)
    for (int k = 0; k < 400 && exp_tel.size() > 0; k++)
      @(negedge i_clk_sys);
    // Whole restart must fit the extended slave watchdog budget
    `CHK(exp_tel.size(), 0)
    settle();
    rd(REG_STATUS, 32'h6);
    @(posedge i_clk_sys);
    i_data_fresh <= 1'b0;
    wr(REG_CTRL, 32'h2);
    settle();
    rd(REG_STATUS, 32'h4);
    mbx(MBX_SET_SLV, 8'h00, 32'h0);
    mbx(MBX_INIT, 8'h20, {AFI_MODE, FI_PARAM});
    wrap_up();
  end

  // Whole sequence needs a few hundred cycles; the watchdog fires after 20000
  initial begin
    #(CLK_PERIOD_NS * 20000);
    fail_count++;
    wrap_up();
  end
endmodule : hot_standby_switchover_test
